// >>> src/sstm_pkg.sv
package sstm_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned AW = 3;
  localparam int unsigned DW = 8;
  localparam logic [AW-1:0] ADDR_CTRL = 3'h0;
  localparam logic [AW-1:0] ADDR_STAT = 3'h1;
  localparam logic [AW-1:0] ADDR_DLO = 3'h2;
  localparam logic [AW-1:0] ADDR_DHI = 3'h3;
  localparam logic [AW-1:0] ADDR_IRQ = 3'h4;
  localparam logic [AW-1:0] ADDR_IEN = 3'h5;
  localparam logic [AW-1:0] ADDR_PMR = 3'h6;

  // ----------------------------------------------------------------
  // serial control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_CKS_LO = 0;
  localparam int unsigned CTRL_CKS_HI = 2;
  localparam int unsigned CTRL_MODE_LOWER = 3;
  localparam int unsigned CTRL_MODE_UPPER = 4;
  localparam int unsigned CTRL_TAIL_SEL = 5;
  localparam int unsigned CTRL_TAIL_EN = 6;

  // ----------------------------------------------------------------
  // serial status, request, enable and port mode fields
  // ----------------------------------------------------------------
  localparam int unsigned STAT_START = 0;
  localparam int unsigned STAT_IDLE_LVL = 1;
  localparam int unsigned STAT_TAIL_ACT = 2;
  localparam int unsigned STAT_BUSY = 3;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IEN_DONE = 0;
  localparam int unsigned PMR_OUT_FN = 0;
  localparam int unsigned PMR_CLK_FN = 1;
  localparam int unsigned PMR_OPEN_DRAIN = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DW-1:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_CKS = 3'h0;
  localparam logic RST_BIT = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned HW = 16;
  // half serial clock period at clock select 0, doubled per select step
  localparam logic [HW-1:0] HALF_BASE_DEF = 16'h0080;
  localparam logic [HW-1:0] ONE_HALF = 16'h0001;

  // ----------------------------------------------------------------
  // shifter
  // ----------------------------------------------------------------
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT16 = 4'hF;
  localparam logic [3:0] BIT_ONE = 4'h1;

  // ----------------------------------------------------------------
  // tail patterns, one entry per half serial clock period
  // ----------------------------------------------------------------
  localparam int unsigned TAIL_STEPS = 8;
  localparam logic [2:0] TAIL_LAST = 3'h7;
  localparam logic [2:0] STEP_ONE = 3'h1;
  localparam logic [TAIL_STEPS-1:0] HOLD_SCL = 8'hFF;
  localparam logic [TAIL_STEPS-1:0] HOLD_SDA = 8'hF0;
  localparam logic [TAIL_STEPS-1:0] LATCH_SCL = 8'hFC;
  localparam logic [TAIL_STEPS-1:0] LATCH_SDA = 8'hCF;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSTM_IDLE = 2'b00,
    SSTM_SHIFT = 2'b01,
    SSTM_TAIL = 2'b10
  } sstm_state_t;

endpackage : sstm_pkg

// >>> src/sstm_div.sv
`timescale 1ns/1ns
module sstm_div (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic run_i,
  input wire logic [sstm_pkg::HW-1:0] half_i,
  // one-cycle tick per half serial period
  output logic tick_o
);

  logic [sstm_pkg::HW-1:0] cnt_q;
  wire wrap_w = (cnt_q == 16'(half_i - sstm_pkg::ONE_HALF));

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !run_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= wrap_w ? '0 : 16'(cnt_q + sstm_pkg::ONE_HALF);
    end
  end

  // tick in the last count cycle, so the first half is not one clock long
  assign tick_o = run_i && wrap_w;

endmodule : sstm_div

// >>> src/sstm_top.sv
`timescale 1ns/1ns
module sstm_top #(
  parameter logic [15:0] HALF_BASE = sstm_pkg::HALF_BASE_DEF
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [sstm_pkg::AW-1:0] reg_addr_i,
  input wire logic [sstm_pkg::DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [sstm_pkg::DW-1:0] reg_rdata_o,
  // interrupt
  output logic irq_o,
  // serial clock line
  output logic scl_o,
  output logic scl_oe_o,
  // serial data line
  output logic sda_o,
  output logic sda_oe_o
);

  // ----------------------------------------------------------------
  // software visible registers
  // ----------------------------------------------------------------
  logic [2:0] cks_q;
  logic mode_lower_q;
  logic mode_upper_q;
  logic tail_sel_q;
  logic tail_en_q;
  logic start_q;
  logic idle_lvl_q;
  logic [sstm_pkg::DW-1:0] dlo_q;
  logic [sstm_pkg::DW-1:0] dhi_q;
  logic done_req_q;
  logic done_ien_q;
  logic out_fn_q;
  logic clk_fn_q;
  logic open_drain_q;

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  sstm_pkg::sstm_state_t state_q;
  sstm_pkg::sstm_state_t state_d;
  logic [15:0] sh_q;
  logic [3:0] bit_cnt_q;
  logic ph_q;
  logic [2:0] step_q;

  // ----------------------------------------------------------------
  // output flops
  // ----------------------------------------------------------------
  logic [sstm_pkg::DW-1:0] rdata_q;
  logic irq_q;
  logic scl_q;
  logic scl_oe_q;
  logic sda_q;
  logic sda_oe_q;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire wr_ctrl_w = reg_wr_i && (reg_addr_i == sstm_pkg::ADDR_CTRL);
  wire wr_stat_w = reg_wr_i && (reg_addr_i == sstm_pkg::ADDR_STAT);
  wire wr_dlo_w = reg_wr_i && (reg_addr_i == sstm_pkg::ADDR_DLO);
  wire wr_dhi_w = reg_wr_i && (reg_addr_i == sstm_pkg::ADDR_DHI);
  wire wr_irq_w = reg_wr_i && (reg_addr_i == sstm_pkg::ADDR_IRQ);
  wire wr_ien_w = reg_wr_i && (reg_addr_i == sstm_pkg::ADDR_IEN);
  wire wr_pmr_w = reg_wr_i && (reg_addr_i == sstm_pkg::ADDR_PMR);

  // control write with tail mode off resets the sequencer
  wire init_w = wr_ctrl_w && !reg_wdata_i[sstm_pkg::CTRL_TAIL_EN];
  wire start_set_w = wr_stat_w && reg_wdata_i[sstm_pkg::STAT_START];
  wire req_clr_w = wr_irq_w && !reg_wdata_i[sstm_pkg::IRQ_DONE];

  // ----------------------------------------------------------------
  // rate select and divider
  // ----------------------------------------------------------------
  wire [sstm_pkg::HW-1:0] half_w = 16'(HALF_BASE << cks_q);
  wire run_w = (state_q != sstm_pkg::SSTM_IDLE);
  wire tick_w;

  sstm_div u_div (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(run_w),
    .half_i(half_w),
    .tick_o(tick_w)
  );

  // ----------------------------------------------------------------
  // sequencer events
  // ----------------------------------------------------------------
  wire in_idle_w = (state_q == sstm_pkg::SSTM_IDLE);
  wire in_shift_w = (state_q == sstm_pkg::SSTM_SHIFT);
  wire in_tail_w = (state_q == sstm_pkg::SSTM_TAIL);
  wire [3:0] last_idx_w = mode_lower_q ? sstm_pkg::LAST_BIT16 : sstm_pkg::LAST_BIT8;
  wire last_bit_w = (bit_cnt_q == last_idx_w);
  // continuous clock mode (upper set) never starts a word
  wire go_w = in_idle_w && start_q && !mode_upper_q && !init_w;
  wire bit_end_w = in_shift_w && tick_w && ph_q;
  wire done_w = bit_end_w && last_bit_w;
  wire tail_end_w = in_tail_w && tick_w && (step_q == sstm_pkg::TAIL_LAST);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      sstm_pkg::SSTM_IDLE: begin
        if (go_w) begin
          state_d = sstm_pkg::SSTM_SHIFT;
        end
      end
      sstm_pkg::SSTM_SHIFT: begin
        if (done_w) begin
          state_d = tail_en_q ? sstm_pkg::SSTM_TAIL : sstm_pkg::SSTM_IDLE;
        end
      end
      sstm_pkg::SSTM_TAIL: begin
        if (tail_end_w) begin
          state_d = sstm_pkg::SSTM_IDLE;
        end
      end
      default: begin
        state_d = sstm_pkg::SSTM_IDLE;
      end
    endcase
    if (init_w) begin
      state_d = sstm_pkg::SSTM_IDLE;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_q <= sstm_pkg::SSTM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // shifter, lsb first
  // ----------------------------------------------------------------
  wire [15:0] load_w = {dhi_q, dlo_q};

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sh_q <= '0;
      bit_cnt_q <= '0;
      ph_q <= 1'b0;
    end else if (go_w) begin
      sh_q <= load_w;
      bit_cnt_q <= '0;
      ph_q <= 1'b0;
    end else if (bit_end_w && !last_bit_w) begin
      sh_q <= sh_q >> 1;
      bit_cnt_q <= 4'(bit_cnt_q + sstm_pkg::BIT_ONE);
      ph_q <= 1'b0;
    end else if (in_shift_w && tick_w && !ph_q) begin
      ph_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // tail step counter
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || done_w) begin
      step_q <= '0;
    end else if (in_tail_w && tick_w) begin
      step_q <= 3'(step_q + sstm_pkg::STEP_ONE);
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cks_q <= sstm_pkg::RST_CKS;
      mode_lower_q <= sstm_pkg::RST_BIT;
      mode_upper_q <= sstm_pkg::RST_BIT;
      tail_sel_q <= sstm_pkg::RST_BIT;
      tail_en_q <= sstm_pkg::RST_BIT;
    end else if (wr_ctrl_w) begin
      cks_q <= reg_wdata_i[sstm_pkg::CTRL_CKS_HI:sstm_pkg::CTRL_CKS_LO];
      mode_lower_q <= reg_wdata_i[sstm_pkg::CTRL_MODE_LOWER];
      mode_upper_q <= reg_wdata_i[sstm_pkg::CTRL_MODE_UPPER];
      tail_sel_q <= reg_wdata_i[sstm_pkg::CTRL_TAIL_SEL];
      tail_en_q <= reg_wdata_i[sstm_pkg::CTRL_TAIL_EN];
    end
  end

  // ----------------------------------------------------------------
  // status, data, request, enable and port mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      start_q <= sstm_pkg::RST_BIT;
      idle_lvl_q <= sstm_pkg::RST_BIT;
      dlo_q <= sstm_pkg::RST_BYTE;
      dhi_q <= sstm_pkg::RST_BYTE;
      done_req_q <= sstm_pkg::RST_BIT;
      done_ien_q <= sstm_pkg::RST_BIT;
      out_fn_q <= sstm_pkg::RST_BIT;
      clk_fn_q <= sstm_pkg::RST_BIT;
      open_drain_q <= sstm_pkg::RST_BIT;
    end else begin
      if (done_w || init_w) begin
        start_q <= 1'b0;
      end else if (start_set_w) begin
        start_q <= 1'b1;
      end
      if (wr_stat_w) begin
        idle_lvl_q <= reg_wdata_i[sstm_pkg::STAT_IDLE_LVL];
      end else if (done_w && !tail_en_q) begin
        // plain mode keeps the last data bit on the line
        idle_lvl_q <= sh_q[0];
      end
      if (wr_dlo_w) begin
        dlo_q <= reg_wdata_i;
      end
      if (wr_dhi_w) begin
        dhi_q <= reg_wdata_i;
      end
      if (done_w) begin
        done_req_q <= 1'b1;
      end else if (req_clr_w) begin
        done_req_q <= 1'b0;
      end
      if (wr_ien_w) begin
        done_ien_q <= reg_wdata_i[sstm_pkg::IEN_DONE];
      end
      if (wr_pmr_w) begin
        out_fn_q <= reg_wdata_i[sstm_pkg::PMR_OUT_FN];
        clk_fn_q <= reg_wdata_i[sstm_pkg::PMR_CLK_FN];
        open_drain_q <= reg_wdata_i[sstm_pkg::PMR_OPEN_DRAIN];
      end
    end
  end

  // ----------------------------------------------------------------
  // line levels
  // ----------------------------------------------------------------
  wire [sstm_pkg::TAIL_STEPS-1:0] tail_scl_w =
    tail_sel_q ? sstm_pkg::LATCH_SCL : sstm_pkg::HOLD_SCL;
  wire [sstm_pkg::TAIL_STEPS-1:0] tail_sda_w =
    tail_sel_q ? sstm_pkg::LATCH_SDA : sstm_pkg::HOLD_SDA;
  wire scl_lvl_w = in_shift_w ? ph_q : (in_tail_w ? tail_scl_w[step_q] : 1'b1);
  // data changes on the falling clock edge, bit 0 first
  wire sda_lvl_w = in_shift_w ? sh_q[0] : (in_tail_w ? tail_sda_w[step_q] : idle_lvl_q);
  // open drain drives only the low level
  wire sda_en_w = out_fn_q && (!open_drain_q || !sda_lvl_w);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [sstm_pkg::DW-1:0] ctrl_rd_w = {1'b0, tail_en_q, tail_sel_q, mode_upper_q,
                                       mode_lower_q, cks_q};
  wire [sstm_pkg::DW-1:0] stat_rd_w = {4'h0, run_w, in_tail_w, idle_lvl_q, start_q};
  wire [sstm_pkg::DW-1:0] irq_rd_w = {7'h00, done_req_q};
  wire [sstm_pkg::DW-1:0] ien_rd_w = {7'h00, done_ien_q};
  wire [sstm_pkg::DW-1:0] pmr_rd_w = {5'h00, open_drain_q, clk_fn_q, out_fn_q};
  wire [sstm_pkg::DW-1:0] rd_mux_w =
    (reg_addr_i == sstm_pkg::ADDR_CTRL) ? ctrl_rd_w :
    (reg_addr_i == sstm_pkg::ADDR_STAT) ? stat_rd_w :
    (reg_addr_i == sstm_pkg::ADDR_DLO) ? dlo_q :
    (reg_addr_i == sstm_pkg::ADDR_DHI) ? dhi_q :
    (reg_addr_i == sstm_pkg::ADDR_IRQ) ? irq_rd_w :
    (reg_addr_i == sstm_pkg::ADDR_IEN) ? ien_rd_w :
    (reg_addr_i == sstm_pkg::ADDR_PMR) ? pmr_rd_w : sstm_pkg::RST_BYTE;

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= sstm_pkg::RST_BYTE;
      irq_q <= 1'b0;
      scl_q <= 1'b1;
      scl_oe_q <= 1'b0;
      sda_q <= 1'b1;
      sda_oe_q <= 1'b0;
    end else begin
      rdata_q <= reg_rd_i ? rd_mux_w : sstm_pkg::RST_BYTE;
      irq_q <= done_req_q && done_ien_q;
      scl_q <= scl_lvl_w;
      scl_oe_q <= clk_fn_q;
      sda_q <= sda_lvl_w;
      sda_oe_q <= sda_en_w;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign irq_o = irq_q;
  assign scl_o = scl_q;
  assign scl_oe_o = scl_oe_q;
  assign sda_o = sda_q;
  assign sda_oe_o = sda_oe_q;

endmodule : sstm_top

// >>> verif/sstm_top_checker.sv
`timescale 1ns/1ns
module sstm_top_checker #(
  parameter logic [15:0] HALF_BASE = sstm_pkg::HALF_BASE_DEF
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [sstm_pkg::AW-1:0] reg_addr_i,
  input wire logic [sstm_pkg::DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [sstm_pkg::DW-1:0] reg_rdata_o,
  // interrupt and lines
  input wire logic irq_o,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic ien_q, ien_p_q, pmr_q, pmr_p_q;
  logic [15:0] low_q;
  wire logic ien_wr = reg_wr_i && reg_addr_i == sstm_pkg::ADDR_IEN;
  wire logic ien_off = ien_wr && !reg_wdata_i[sstm_pkg::IEN_DONE];
  wire logic pmr_wr = reg_wr_i && reg_addr_i == sstm_pkg::ADDR_PMR;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ien_q <= 1'b0;
      ien_p_q <= 1'b0;
      pmr_q <= 1'b0;
      pmr_p_q <= 1'b0;
      low_q <= 16'h0000;
    end else begin
      ien_q <= ien_wr ? reg_wdata_i[sstm_pkg::IEN_DONE] : ien_q;
      ien_p_q <= ien_q;
      pmr_q <= pmr_wr;
      pmr_p_q <= pmr_q;
      low_q <= scl_o ? 16'h0000 : low_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  reset_out_a: assert property (@(posedge ref_clk_i) disable iff (1'b0)
    sys_rst_i |=> scl_o && !scl_oe_o && sda_o && !sda_oe_o && !irq_o && reg_rdata_o == 8'h00)
    else $error("outputs not at reset levels");
  rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
  unmapped_rd_a: assert property (reg_rd_i && reg_addr_i == 3'h7 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  irq_gate_a: assert property (irq_o |-> ien_q || ien_p_q)
    else $error("irq while disabled");
  irq_mask_a: assert property (ien_off |=> ##1 !irq_o)
    else $error("irq not masked");
  low_len_a: assert property ($rose(scl_o) |->
    low_q != 16'h0000 && low_q % HALF_BASE == 16'h0000)
    else $error("clock low time not a unit multiple");
  sda_steady_a: assert property (!scl_o && !$fell(scl_o) |-> $stable(sda_o))
    else $error("data moved while clock low");
  clk_drive_a: assert property ($changed(scl_oe_o) |-> pmr_q || pmr_p_q)
    else $error("clock drive changed unasked");
endmodule : sstm_top_checker

bind sstm_top sstm_top_checker #(.HALF_BASE(HALF_BASE)) u_chk (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o)
);

// >>> verif/sstm_target.sv
`timescale 1ns/1ns
module sstm_target (
  // clock and control
  input wire logic ref_clk_i,
  input wire logic clear_i,
  // shared serial lines
  input wire logic scl_i,
  input wire logic sda_i,
  // observations
  output logic [16:0] bits_o,
  output logic [4:0] bit_cnt_o,
  output logic [3:0] rise_hi_o,
  output logic [3:0] fall_hi_o,
  output logic [15:0] low_len_o
);
  // listener only: never drives a line or a clock
  logic scl_p, sda_p;
  logic [15:0] run_q;
  wire logic scl_up = scl_i && !scl_p;
  wire logic both_hi = scl_i && scl_p;

  always @(posedge ref_clk_i) begin
    scl_p <= scl_i;
    sda_p <= sda_i;
    run_q <= scl_i ? 16'h0000 : run_q + 16'h0001;
    if (clear_i) begin
      bits_o <= 17'h00000;
      bit_cnt_o <= 5'h00;
      rise_hi_o <= 4'h0;
      fall_hi_o <= 4'h0;
      low_len_o <= 16'h0000;
    end else begin
      if (scl_up && bit_cnt_o < 5'h11) begin
        bits_o[bit_cnt_o] <= sda_i;
        bit_cnt_o <= bit_cnt_o + 5'h01;
      end
      if (scl_up && low_len_o == 16'h0000) begin
        low_len_o <= run_q;
      end
      if (both_hi && sda_i && !sda_p) begin
        rise_hi_o <= rise_hi_o + 4'h1;
      end
      if (both_hi && !sda_i && sda_p) begin
        fall_hi_o <= fall_hi_o + 4'h1;
      end
    end
  end
endmodule : sstm_target

// >>> verif/sstm_top_tb.sv
`timescale 1ns/1ns
module sstm_top_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [15:0] HB = 16'h0005;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic clr = 1'b1;
  logic [7:0] reg_rdata_o, rd_v;
  logic irq_o, scl_o, scl_oe_o, sda_o, sda_oe_o;
  logic [16:0] bits;
  logic [4:0] bit_cnt;
  logic [3:0] rise_hi, fall_hi;
  logic [15:0] low_len;
  int err_count = 0;
  int cmp_count = 0;
  wire logic scl_line = scl_oe_o ? scl_o : 1'b1;
  wire logic sda_line = sda_oe_o ? sda_o : 1'b1;

  always #4 ref_clk_i = ~ref_clk_i; // single main clock, no subclock mode

  sstm_top #(.HALF_BASE(HB)) dut (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o));
  sstm_target tgt (.ref_clk_i(ref_clk_i), .clear_i(clr), .scl_i(scl_line),
    .sda_i(sda_line), .bits_o(bits), .bit_cnt_o(bit_cnt), .rise_hi_o(rise_hi),
    .fall_hi_o(fall_hi), .low_len_o(low_len));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    d = reg_rdata_o;
  endtask : rd

  task automatic wait_bit(input logic [2:0] a, input int b, input logic v);
    for (int k = 0; k < 2000; k++) begin
      rd(a, rd_v);
      if (rd_v[b] === v) return;
    end
    err_count++;
    $display("mismatch at %0t: wait limit", $time);
    summarize();
  endtask : wait_bit

  task automatic xfer(input logic len16, input logic latch, input logic [2:0] cks,
                      input logic ien);
    logic [15:0] d;
    int n;
    int exp_q[$];
    d = 16'($urandom);
    n = len16 ? 16 : 8;
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(int'(d[i]));
    end
    wr(sstm_pkg::ADDR_IEN, {7'h00, ien});
    wr(sstm_pkg::ADDR_DLO, d[7:0]);
    wr(sstm_pkg::ADDR_DHI, d[15:8]);
    wr(sstm_pkg::ADDR_CTRL, {2'b01, latch, 1'b1, len16, cks});
    clr <= 1'b1;
    @(posedge ref_clk_i);
    clr <= 1'b0;
    wr(sstm_pkg::ADDR_STAT, 8'h03);
    rd(sstm_pkg::ADDR_STAT, rd_v); // held by upper mode bit
    chk(rd_v[sstm_pkg::STAT_START], 1'b1, "start flag low");
    chk(rd_v[sstm_pkg::STAT_BUSY], 1'b0, "upper mode started");
    wr(sstm_pkg::ADDR_CTRL, {2'b01, latch, 1'b0, len16, cks});
    wait_bit(sstm_pkg::ADDR_IRQ, sstm_pkg::IRQ_DONE, 1'b1);
    rd(sstm_pkg::ADDR_STAT, rd_v);
    chk(rd_v[sstm_pkg::STAT_START], 1'b0, "start flag kept");
    chk(rd_v[sstm_pkg::STAT_TAIL_ACT], 1'b1, "tail flag low");
    chk(irq_o, ien, "irq gating");
    if (!ien) begin
      wr(sstm_pkg::ADDR_IEN, 8'h01);
      rd(sstm_pkg::ADDR_IRQ, rd_v);
      chk(irq_o, 1'b1, "irq not raised");
    end
    wait_bit(sstm_pkg::ADDR_STAT, sstm_pkg::STAT_TAIL_ACT, 1'b0);
    chk(bit_cnt, 32'(n + latch), "clock count");
    for (int i = 0; i < n; i++) begin
      chk(bits[i], exp_q.pop_front(), "data bit");
    end
    if (latch) chk(bits[n], 1'b1, "latch tail clock");
    chk(rise_hi, 4'h1, "tail rise");
    chk(fall_hi, latch ? 4'h1 : {3'h0, d[n-1]}, "tail fall");
    chk(low_len, HB << cks, "clock unit");
    chk({scl_line, sda_line}, 2'b11, "idle levels");
    wr(sstm_pkg::ADDR_IRQ, 8'h00);
    rd(sstm_pkg::ADDR_IRQ, rd_v);
    chk(rd_v, 8'h00, "request kept");
    chk(irq_o, 1'b0, "irq stuck");
  endtask : xfer

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(80));
    repeat (6) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    clr <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), rd_v);
      chk(rd_v, 8'h00, "reset value");
    end
    wr(3'h7, 8'hFF);
    rd(3'h7, rd_v);
    chk(rd_v, 8'h00, "unmapped read");
    wr(sstm_pkg::ADDR_STAT, 8'h02);
    wr(sstm_pkg::ADDR_PMR, 8'h07);
    rd(sstm_pkg::ADDR_PMR, rd_v);
    chk(rd_v, 8'h07, "port mode readback");
    chk(scl_oe_o, 1'b1, "clock drive off");
    for (int t = 0; t < 4; t++) begin
      xfer(t[0], t[1], 3'(t % 3), t != 2);
    end
    summarize();
  end
endmodule : sstm_top_tb
